// [design/baud_tick_gen.sv]
// Divider that makes the sixteen-times bit rate enable pulse
`timescale 1ns/10ps
module baud_tick_gen (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] divisor_in,
  output logic            tick_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } state_t;
  state_t cur_q;
  state_t nxt_d;

  // Count down from divisor; pulse when reaching zero
  always_comb begin
    nxt_d = cur_q;
    nxt_d.tick = 1'b0;
    if (cur_q.cnt == 8'h00) begin
      nxt_d.cnt  = divisor_in;
      nxt_d.tick = 1'b1;
    end else begin
      nxt_d.cnt = cur_q.cnt - 8'h01;
    end
  end

  // Register stage
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign tick_out = cur_q.tick;
endmodule // baud_tick_gen

// [design/serial_port.sv]
// Full-duplex asynchronous serial port with shared data register
`timescale 1ns/10ps
module serial_port (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       rxd_in,
  output logic            txd_out,
  input  wire logic       tx_done_ack_in,
  output logic            rx_complete_irq_out,
  output logic            tx_complete_irq_out,
  output logic            tx_empty_irq_out
);
  // Transmit sequencer; codes two and three never occur
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;

  // Receive sequencer: hunt, confirm start, data bits, stop bit
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  // Whole block state, registered in one place
  typedef struct packed {
    // Host-visible settings
    logic [7:0]  control;
    logic [7:0]  divisor;
    // Transmit holding, flags and received data
    logic [7:0]  tx_hold;
    logic        hold_empty;
    logic        tx_done;
    logic        rx_full;
    logic        frame_err;
    logic        overrun;
    logic        rx_nine;
    logic [7:0]  rx_data;
    // Transmit shifter
    tx_state_t   tx_st;
    logic [10:0] tx_shift;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_tick;
    // Receive shifter and line synchroniser
    rx_state_t   rx_st;
    logic [8:0]  rx_shift;
    logic [3:0]  rx_bits;
    logic [3:0]  rx_tick;
    logic        rx_s1;
    logic        rx_s2;
    // Read data stage
    logic [7:0]  rdata;
  } state_t;

  state_t cur_q;
  state_t nxt_d;
  logic   tick;

  // Usage notes and limitations
  // Bit time is sixteen ticks of the divider enable
  // Divider ticks every divisor plus one clocks
  // Divisor zero gives a tick every clock, the fastest rate
  // Changing the divisor mid-frame bends the bit in flight
  // Transmit enable low parks a written character in holding
  // Clearing transmit enable mid-frame still finishes that frame
  // Receive enable gates only the hunt for a start bit
  // A frame already being received always runs to its stop bit
  // Nine-bit select should stay fixed while frames are in flight
  // Control bit one is read-only and mirrors the last ninth bit
  // Ninth-bit mirror is cleared by a frame in eight-bit mode
  // Holding register is one deep; a second write overwrites it
  // Software checks the holding-empty flag before each write
  // Overrun keeps the newest character; the older one is lost
  // Overrun and framing error clear on a data register read
  // Framing error is one sample near the middle of the stop bit
  // Start bit confirmed half a bit after the falling edge
  // Line back high at that point is a false start, ignored
  // Lows shorter than half a bit never start a frame
  // No majority vote: one sample per bit, no noise filter
  // A low stop bit is followed by a fresh hunt for a start
  // Sampling point drifts with any rate mismatch between ends
  // Set beats clear when an event and a host access coincide, except for holding-empty and overrun
  // Same-cycle data write keeps holding-empty low
  // Same-cycle completion keeps receive-complete high on a read
  // Vector acknowledge is a one-cycle pulse from the interrupt unit
  // Interrupt outputs are levels; the interrupt unit latches them
  // Read strobe on an unmapped offset returns zero
  // Writes to unmapped offsets are ignored
  // Read data stand one cycle after the strobe, then read zero
  // Status and control reads have no side effects

  baud_tick_gen u_tick (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .divisor_in  (cur_q.divisor),
    .tick_out    (tick)
  );

  // Bits in a frame including start and stop
  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? serial_port_pkg::FRAME_LEN_9 : serial_port_pkg::FRAME_LEN_8;
  endfunction

  // Frame image, position 0 first on the line; spare top position stays one
  function automatic logic [10:0] build_frame(input logic [7:0] data,
                                              input logic       nine,
                                              input logic       ninth);
    build_frame = {2'b11, data, 1'b0};
    if (nine) begin
      build_frame[9] = ninth;
    end
  endfunction

  // Status byte as software sees it; low three bits read zero
  function automatic logic [7:0] pack_status(input state_t s);
    pack_status = 8'h00;
    pack_status[serial_port_pkg::RX_COMPLETE_BIT] = s.rx_full;
    pack_status[serial_port_pkg::TX_COMPLETE_BIT] = s.tx_done;
    pack_status[serial_port_pkg::HOLD_EMPTY_BIT]  = s.hold_empty;
    pack_status[serial_port_pkg::FRAME_ERR_BIT]   = s.frame_err;
    pack_status[serial_port_pkg::OR_BIT]          = s.overrun;
  endfunction

  // Host access decode; strobes are single-cycle pulses
  logic data_wr;
  logic data_rd;
  assign data_wr = wr_in && (addr_in == serial_port_pkg::DATA_ADDR);
  assign data_rd = rd_in && (addr_in == serial_port_pkg::DATA_ADDR);

  // Control fields; nine-bit select read by both halves, each enable by its own half
  logic nine_mode;
  logic tx_enabled;
  logic rx_enabled;
  assign nine_mode  = cur_q.control[serial_port_pkg::NINE_BIT_SEL_BIT];
  assign tx_enabled = cur_q.control[serial_port_pkg::TXEN_BIT];
  assign rx_enabled = cur_q.control[serial_port_pkg::RXEN_BIT];

  always_comb begin
    logic [10:0] frame;
    logic        loaded;
    logic        tx_end;
    logic        rx_done;
    frame   = '0;
    loaded  = 1'b0;
    tx_end  = 1'b0;
    rx_done = 1'b0;
    nxt_d   = cur_q;
    // Two-flop synchroniser on the line input
    nxt_d.rx_s1 = rxd_in;
    nxt_d.rx_s2 = cur_q.rx_s1;

    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        serial_port_pkg::CONTROL_ADDR: begin
          // Received ninth bit is status, not writable
          nxt_d.control = {wdata_in[7:2], cur_q.control[1], wdata_in[0]};
        end
        serial_port_pkg::DIVISOR_ADDR: begin
          // New rate applies from the divider's next reload
          nxt_d.divisor = wdata_in;
        end
        serial_port_pkg::DATA_ADDR: begin
          // Holding takes the character; the empty flag drops
          nxt_d.tx_hold    = wdata_in;
          nxt_d.hold_empty = 1'b0;
        end
        serial_port_pkg::STATUS_ADDR: begin
          // Only transmit-complete is writable, by a one
          if (wdata_in[serial_port_pkg::TX_COMPLETE_BIT]) begin
            nxt_d.tx_done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (tx_done_ack_in) begin
      nxt_d.tx_done = 1'b0;
    end

    // Transmitter; shifter position 0 is on the line first
    if (tick && cur_q.tx_st == TX_SHIFT) begin
      nxt_d.tx_tick = cur_q.tx_tick + 4'h1;
      if (cur_q.tx_tick == serial_port_pkg::TICKS_LAST) begin
        nxt_d.tx_shift = {1'b1, cur_q.tx_shift[10:1]};
        nxt_d.tx_bits  = cur_q.tx_bits - 4'h1;
        if (cur_q.tx_bits == 4'h1) begin
          tx_end      = 1'b1; // Stop bit fully sent
          nxt_d.tx_st = TX_IDLE;
        end
      end
    end
    // Load from holding when idle or just after the stop bit
    if ((cur_q.tx_st == TX_IDLE || tx_end) && !cur_q.hold_empty
        && tx_enabled) begin
      loaded = 1'b1;
      frame  = build_frame(cur_q.tx_hold, nine_mode,
          cur_q.control[serial_port_pkg::TX_NINTH_BIT]);
      nxt_d.tx_shift = frame;
      nxt_d.tx_bits  = frame_len(nine_mode);
      nxt_d.tx_tick  = 4'h0;
      nxt_d.tx_st    = TX_SHIFT;
      // Holding is free again; a same-cycle write still wins
      if (!data_wr) begin
        nxt_d.hold_empty = 1'b1;
      end
    end
    // Complete only when no next character is loaded to follow
    if (tx_end && !loaded) begin
      nxt_d.tx_done = 1'b1;
    end

    // Receiver, sampling mid-bit at sixteen ticks per bit
    if (tick) begin
      nxt_d.rx_tick = cur_q.rx_tick + 4'h1;
      unique case (cur_q.rx_st)
        RX_IDLE: begin
          nxt_d.rx_tick = 4'h0;
          // Low line after idle may be a start bit
          if (!cur_q.rx_s2 && rx_enabled) begin
            nxt_d.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (cur_q.rx_tick == serial_port_pkg::TICK_MID) begin
            nxt_d.rx_tick = 4'h0;
            // False start rejected if line went back high
            nxt_d.rx_st   = cur_q.rx_s2 ? RX_IDLE : RX_DATA;
            nxt_d.rx_bits = nine_mode ? serial_port_pkg::DATA_LEN_9 : serial_port_pkg::DATA_LEN_8;
            nxt_d.rx_shift = '0;
          end
        end
        RX_DATA: begin
          // Shift in at the middle of each data bit
          if (cur_q.rx_tick == serial_port_pkg::TICKS_LAST) begin
            nxt_d.rx_shift = {cur_q.rx_s2, cur_q.rx_shift[8:1]};
            nxt_d.rx_bits  = cur_q.rx_bits - 4'h1;
            if (cur_q.rx_bits == 4'h1) begin
              nxt_d.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // Stop bit sampled once, at its middle
          if (cur_q.rx_tick == serial_port_pkg::TICKS_LAST) begin
            rx_done     = 1'b1;
            nxt_d.rx_st = RX_IDLE;
          end
        end
      endcase
    end

    // Receive data read clears flags; new completion wins over it
    if (data_rd) begin
      nxt_d.rx_full   = 1'b0;
      nxt_d.frame_err = 1'b0;
      nxt_d.overrun   = 1'b0;
    end
    if (rx_done) begin
      nxt_d.overrun   = cur_q.rx_full && !data_rd;
      nxt_d.rx_full   = 1'b1;
      nxt_d.frame_err = !cur_q.rx_s2;
      if (nine_mode) begin
        nxt_d.rx_data = cur_q.rx_shift[7:0];
        nxt_d.rx_nine = cur_q.rx_shift[8];
      end else begin
        nxt_d.rx_data = cur_q.rx_shift[8:1];
        nxt_d.rx_nine = 1'b0;
      end
    end
    // Control bit one mirrors the ninth received bit
    nxt_d.control[serial_port_pkg::RX_NINTH_BIT] = nxt_d.rx_nine;

    // Read data stand one cycle after the strobe
    nxt_d.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        serial_port_pkg::DATA_ADDR:    nxt_d.rdata = cur_q.rx_data;
        serial_port_pkg::CONTROL_ADDR: nxt_d.rdata = cur_q.control;
        serial_port_pkg::DIVISOR_ADDR: nxt_d.rdata = cur_q.divisor;
        serial_port_pkg::STATUS_ADDR:  nxt_d.rdata = pack_status(cur_q);
        default: nxt_d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cur_q            <= '0;
      cur_q.control    <= serial_port_pkg::CONTROL_RESET;
      cur_q.divisor    <= serial_port_pkg::DIVISOR_RESET;
      // Line idles high; holding starts empty
      cur_q.hold_empty <= 1'b1;
      cur_q.tx_shift   <= 11'h7FF;
      cur_q.rx_s1      <= 1'b1;
      cur_q.rx_s2      <= 1'b1;
      cur_q.tx_st      <= TX_IDLE;
      cur_q.rx_st      <= RX_IDLE;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Outputs; interrupt levels follow flags and enables
  assign rdata_out = cur_q.rdata;
  assign txd_out   = (cur_q.tx_st == TX_SHIFT) ? cur_q.tx_shift[0] : 1'b1;
  // Receive request stays up until the data register is read
  assign rx_complete_irq_out = cur_q.rx_full
      && cur_q.control[serial_port_pkg::RX_IRQ_EN_BIT];
  // Drops on vector acknowledge or a write of one
  assign tx_complete_irq_out = cur_q.tx_done
      && cur_q.control[serial_port_pkg::TX_IRQ_EN_BIT];
  // Level request, held for as long as holding is empty
  assign tx_empty_irq_out = cur_q.hold_empty
      && cur_q.control[serial_port_pkg::EMPTY_IRQ_EN_BIT];
endmodule // serial_port

// [design/serial_port_pkg.sv]
// Constants shared by the serial port design files
package serial_port_pkg;
  // Register offsets
  localparam logic [7:0] CONTROL_ADDR  = 8'h0A;
  localparam logic [7:0] STATUS_ADDR   = 8'h0B;
  localparam logic [7:0] DATA_ADDR     = 8'h0C;
  localparam logic [7:0] DIVISOR_ADDR  = 8'h09;
  // Status bit positions
  localparam int RX_COMPLETE_BIT = 7;
  localparam int TX_COMPLETE_BIT = 6;
  localparam int HOLD_EMPTY_BIT  = 5;
  localparam int FRAME_ERR_BIT   = 4;
  localparam int OR_BIT          = 3;
  // Control bit positions
  localparam int RX_IRQ_EN_BIT    = 7;
  localparam int TX_IRQ_EN_BIT    = 6;
  localparam int EMPTY_IRQ_EN_BIT = 5;
  localparam int RXEN_BIT         = 4;
  localparam int TXEN_BIT         = 3;
  localparam int NINE_BIT_SEL_BIT = 2;
  localparam int RX_NINTH_BIT     = 1;
  localparam int TX_NINTH_BIT     = 0;
  // Reset values
  localparam logic [7:0] STATUS_RESET  = 8'h20;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  // Oversampling: sixteen ticks per bit, middle sample at eight
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [3:0] TICK_MID   = 4'h7;
  // Frame lengths with start and stop, and data bit counts
  localparam logic [3:0] FRAME_LEN_8 = 4'hA;
  localparam logic [3:0] FRAME_LEN_9 = 4'hB;
  localparam logic [3:0] DATA_LEN_8  = 4'h8;
  localparam logic [3:0] DATA_LEN_9  = 4'h9;
endpackage

// [verification/serial_peer_model.sv]
// Far-end serial peer: frame sender and frame catcher
`timescale 1ns/10ps
module serial_peer_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic core_clk_in,
  input  wire logic txd_in,
  input  wire logic nine_in,
  output logic      rxd_out
);
  logic [9:0] got_q[$];
  logic [9:0] w;
  int         m;
  initial rxd_out = 1'b1;
  // Start low, data LSB first, stop, then one idle bit so completions settle
  task automatic send(input logic [8:0] d, input logic stop);
    logic [11:0] fr;
    int          n;
    n = nine_in ? 9 : 8;
    fr = {2'b11, d, 1'b0};
    fr[n + 1] = stop;
    for (int i = 0; i < n + 3; i++) begin
      @(posedge core_clk_in);
      rxd_out <= fr[i];
      repeat (BIT_CLKS - 1) @(posedge core_clk_in);
    end
  endtask
  // Catch frames mid-bit; stored as {stop, ninth, data}
  always begin
    @(negedge txd_in);
    w = 10'h000;
    m = nine_in ? 9 : 8;
    repeat (BIT_CLKS / 2) @(posedge core_clk_in);
    for (int i = 0; i <= m; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk_in);
      w[(i == m) ? 9 : i] = txd_in;
    end
    got_q.push_back(w);
  end
endmodule // serial_peer_model

// [verification/serial_port_sva.sv]
// Port-level assertions for the serial port
`timescale 1ns/10ps
module serial_port_sva (
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rxd_in,
  input wire logic       txd_out,
  input wire logic       tx_done_ack_in,
  input wire logic       rx_complete_irq_out,
  input wire logic       tx_complete_irq_out,
  input wire logic       tx_empty_irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Host accesses that move the flags
  sequence s_data_wr;
    wr_in && addr_in == serial_port_pkg::DATA_ADDR;
  endsequence
  sequence s_data_rd;
    rd_in && addr_in == serial_port_pkg::DATA_ADDR;
  endsequence
  sequence s_status_one;
    wr_in && addr_in == serial_port_pkg::STATUS_ADDR
      && wdata_in[serial_port_pkg::TX_COMPLETE_BIT];
  endsequence
  a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside the read slot");
  a_unmapped_reads_zero: assert property (
    rd_in && addr_in == 8'h00 |=> rdata_out == 8'h00)
    else $error("unmapped read returned nonzero");
  a_write_clears_empty: assert property (s_data_wr |=> !tx_empty_irq_out)
    else $error("empty request survived a data write");
  a_read_clears_recv: assert property (s_data_rd |=> !rx_complete_irq_out)
    else $error("receive request survived a data read");
  a_ack_clears_done: assert property (tx_done_ack_in |=> !tx_complete_irq_out)
    else $error("transmit complete survived vector ack");
  a_one_clears_done: assert property (s_status_one |=> !tx_complete_irq_out)
    else $error("transmit complete survived write of one");
  a_start_bit_len: assert property ($fell(txd_out) |-> !txd_out [*8])
    else $error("start bit too short");
  a_done_line_idle: assert property (tx_complete_irq_out |-> txd_out)
    else $error("transmit complete while line not idle");
endmodule // serial_port_sva

bind serial_port serial_port_sva u_serial_port_sva (.core_clk_in(core_clk_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .rxd_in(rxd_in), .txd_out(txd_out),
  .tx_done_ack_in(tx_done_ack_in), .rx_complete_irq_out(rx_complete_irq_out),
  .tx_complete_irq_out(tx_complete_irq_out), .tx_empty_irq_out(tx_empty_irq_out));

// [verification/tb_top.sv]
// Self-checking bench for the serial port
`timescale 1ns/10ps
module tb_top;
  logic       core_clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       ack = 1'b0;
  logic       nine = 1'b0;
  logic [7:0] rdata_out, rv;
  logic       rxd, txd, rx_irq, done_irq, empty_irq;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         k;
  always #5 core_clk_in = ~core_clk_in;
  serial_port u_serial_port (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd),
    .txd_out(txd), .tx_done_ack_in(ack), .rx_complete_irq_out(rx_irq),
    .tx_complete_irq_out(done_irq), .tx_empty_irq_out(empty_irq));
  // Divisor 1: sixteen ticks of two clocks per bit
  serial_peer_model #(.BIT_CLKS(32)) u_serial_peer_model (.core_clk_in(core_clk_in),
    .txd_in(txd), .nine_in(nine), .rxd_out(rxd));
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask
  task automatic close_out;
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, well beyond the seven frames below
  initial begin
    repeat (60000) @(posedge core_clk_in);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rd(serial_port_pkg::STATUS_ADDR); chk("status", 8'h20, rv);
    rd(8'h00); chk("unmapped", 8'h00, rv);
    chk("empty irq masked", 1'b0, empty_irq);
    wr(serial_port_pkg::DIVISOR_ADDR, 8'h01);
    wr(serial_port_pkg::CONTROL_ADDR, 8'hF8);
    #1 chk("empty irq", 1'b1, empty_irq);
    $display("Test reset done");
    // Second character written mid-frame must wait
    wr(serial_port_pkg::DATA_ADDR, 8'hA5);
    wr(serial_port_pkg::DATA_ADDR, 8'h3C);
    rd(serial_port_pkg::STATUS_ADDR); chk("empty held", 1'b0, rv[5]);
    for (k = 0; k < 2000 && empty_irq !== 1'b1; k++) begin @(posedge core_clk_in); #1; end
    chk("frames at load", 1, u_serial_peer_model.got_q.size());
    for (k = 0; k < 2000 && done_irq !== 1'b1; k++) begin @(posedge core_clk_in); #1; end
    chk("frame 1", 10'h2A5, u_serial_peer_model.got_q[0]);
    chk("frame 2", 10'h23C, u_serial_peer_model.got_q[1]);
    rd(serial_port_pkg::STATUS_ADDR); chk("status done", 8'h60, rv);
    wr(serial_port_pkg::STATUS_ADDR, 8'h00);
    #1 chk("tx done kept", 1'b1, done_irq);
    wr(serial_port_pkg::STATUS_ADDR, 8'h40);
    #1 chk("tx done cleared", 1'b0, done_irq);
    $display("Test transmit done");
    // Nine-bit transmit, then vector acknowledge
    nine <= 1'b1;
    wr(serial_port_pkg::CONTROL_ADDR, 8'hFD);
    wr(serial_port_pkg::DATA_ADDR, 8'h81);
    for (k = 0; k < 2000 && done_irq !== 1'b1; k++) begin @(posedge core_clk_in); #1; end
    chk("frame 9", 10'h381, u_serial_peer_model.got_q[2]);
    @(posedge core_clk_in);
    ack <= 1'b1;
    @(posedge core_clk_in);
    ack <= 1'b0;
    #1 chk("tx done acked", 1'b0, done_irq);
    // Nine-bit receive serviced by reading data
    u_serial_peer_model.send(9'h15A, 1'b1);
    chk("rx irq", 1'b1, rx_irq);
    rd(serial_port_pkg::CONTROL_ADDR); chk("rx ninth", 8'hFF, rv);
    rd(serial_port_pkg::DATA_ADDR); chk("rx data", 8'h5A, rv);
    #1 chk("rx irq clear", 1'b0, rx_irq);
    $display("Test nine bit done");
    // Zero stop bit, then two unread characters
    nine <= 1'b0;
    wr(serial_port_pkg::CONTROL_ADDR, 8'hF8);
    u_serial_peer_model.send(9'h0C3, 1'b0);
    rd(serial_port_pkg::STATUS_ADDR); chk("framing", 8'hB0, rv);
    rd(serial_port_pkg::DATA_ADDR); chk("framed data", 8'hC3, rv);
    u_serial_peer_model.send(9'h011, 1'b1);
    u_serial_peer_model.send(9'h022, 1'b1);
    rd(serial_port_pkg::STATUS_ADDR); chk("overrun", 8'hA8, rv);
    rd(serial_port_pkg::DATA_ADDR); chk("overrun data", 8'h22, rv);
    $display("Test receive errors done");
    close_out();
  end
endmodule // tb_top
